/* hdl/pipelined_adc_sample_port.v */
`timescale 1ns/1ps
`include "sample_port_defines.vh"

// Summary of operation
// RULE1 - High output enable floats sample pins
// RULE2 - Power-down request high stops conversion
// RULE3 - Span select high 2V, low 1V
// RULE4 - Reference select high external, low internal
// RULE5 - Ten-bit word, sample_msb down to sample_lsb
// RULE6 - New data valid at rising clock edge
// RULE7 - Output word five clocks after sampling
// RULE8 - Every ten-bit code reachable, none missing
// RULE9 - Input sampled on rising clock edge
// RULE10 - Straight offset binary; MSB flip gives two's
// RULE11 - Open span/reference pins default 2V, external
// RULE12 - Capturer discards first five words, aligns
module pipelined_adc_sample_port
#(
	parameter SW      = `SAMPLE_WIDTH,
	parameter LW      = `LEVEL_WIDTH,
	parameter LATENCY = `PIPE_LATENCY,
	parameter DEPTH   = `FIFO_DEPTH
)
(
	input  wire          aclk,
	input  wire          aresetn,
	input  wire [LW-1:0] analog_level,
	input  wire          output_enable_n,
	input  wire          power_down_request,
	input  wire          input_span_select,
	input  wire          reference_source_select,
	output wire [SW-1:0] sample_out,
	output wire [SW-1:0] sample_oe,
	output wire          sample_valid,
	output wire          internal_ref_active,
	input  wire [3:0]    s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output wire          s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output wire          s_axi_wready,
	output wire [1:0]    s_axi_bresp,
	output wire          s_axi_bvalid,
	input  wire          s_axi_bready,
	input  wire [3:0]    s_axi_araddr,
	input  wire          s_axi_arvalid,
	output wire          s_axi_arready,
	output wire [31:0]   s_axi_rdata,
	output wire [1:0]    s_axi_rresp,
	output wire          s_axi_rvalid,
	input  wire          s_axi_rready
);
	// Static pins: two-flop synchronisers, reset to the pull defaults
	reg  [3:0]    pin_meta_ff;
	reg  [3:0]    pin_sync_ff;
	wire          oen_s;
	wire          pd_s;
	wire          span_s;
	wire          ref_s;

	// Conversion pipeline
	reg  [SW-1:0] stage_ff [0:LATENCY-1];
	reg  [SW-1:0] sample_out_ff;
	reg  [SW-1:0] sample_oe_ff;
	reg           sample_valid_ff;
	reg           int_ref_ff;
	reg  [2:0]    fill_ff;
	reg  [SW-1:0] nxt_code;
	reg  [LW-1:0] shifted;

	// Register file
	reg  [1:0]    ctrl_ff;
	reg  [15:0]   drop_ff;
	reg           aw_held_ff;
	reg           w_held_ff;
	reg  [3:0]    aw_addr_ff;
	reg  [31:0]   w_data_ff;
	reg  [3:0]    w_strb_ff;
	reg           awready_ff;
	reg           wready_ff;
	reg           bvalid_ff;
	reg  [1:0]    bresp_ff;
	reg           arready_ff;
	reg           rvalid_ff;
	reg  [31:0]   rdata_ff;
	reg  [1:0]    rresp_ff;
	reg  [31:0]   nxt_rdata;
	reg  [1:0]    nxt_rresp;

	// FIFO between the sample stream and the data register
	wire          fifo_in_valid;
	wire          fifo_in_ready;
	wire [SW-1:0] fifo_out_data;
	wire          fifo_out_valid;
	wire          fifo_pop;
	wire [2:0]    fifo_level;
	wire          ar_take;
	wire          ar_is_data;
	wire          do_write;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_meta_ff <= {`PIN_REF_DEFAULT, `PIN_SPAN_DEFAULT,
			                `PIN_PD_DEFAULT, `PIN_OEN_DEFAULT}; // RULE1 RULE11
			pin_sync_ff <= {`PIN_REF_DEFAULT, `PIN_SPAN_DEFAULT,
			                `PIN_PD_DEFAULT, `PIN_OEN_DEFAULT}; // RULE1 RULE11
		end
		else
		begin
			pin_meta_ff <= {reference_source_select, input_span_select,
			                power_down_request, output_enable_n};
			pin_sync_ff <= pin_meta_ff;
		end
	end

	assign oen_s  = pin_sync_ff[0];
	assign pd_s   = pin_sync_ff[1];
	assign span_s = pin_sync_ff[2];
	assign ref_s  = pin_sync_ff[3];

	// Level LSB is a 1V-span code step, so both spans cover all codes
	always @*
	begin
		shifted  = {LW{1'b0}};
		nxt_code = {SW{1'b0}};
		if (span_s)
			nxt_code = analog_level[LW-1:1]; // RULE3 RULE8
		else
		begin
			// 1V span: window centred on midscale, clipped at the ends
			if (analog_level < `SPAN_1V_OFFSET)
				nxt_code = {SW{1'b0}}; // RULE3
			else
			begin
				shifted = analog_level - `SPAN_1V_OFFSET;
				if (shifted[LW-1])
					nxt_code = `CODE_MAX; // RULE3
				else
					nxt_code = shifted[SW-1:0]; // RULE3 RULE8
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < LATENCY; gi = gi + 1)
		begin : g_stage
			always @(posedge aclk)
			begin
				if (!aresetn)
					stage_ff[gi] <= {SW{1'b0}};
				else if (gi == 0)
					stage_ff[gi] <= nxt_code; // RULE9
				else
					stage_ff[gi] <= stage_ff[(gi > 0) ? gi - 1 : 0]; // RULE7
			end
		end
	endgenerate

	// Sample at edge k reaches sample_out at edge k+LATENCY
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sample_out_ff   <= {SW{1'b0}};
			sample_oe_ff    <= {SW{1'b0}};
			sample_valid_ff <= 1'b0;
			int_ref_ff      <= 1'b0;
			fill_ff         <= 3'h0;
		end
		else
		begin
			sample_oe_ff <= {SW{~oen_s}}; // RULE1
			int_ref_ff   <= ~ref_s; // RULE4
			if (pd_s)
			begin
				// Powered down: output parked, latency count restarts
				sample_out_ff   <= {SW{1'b0}}; // RULE2
				sample_valid_ff <= 1'b0; // RULE2
				fill_ff         <= 3'h0; // RULE2
			end
			else
			begin
				sample_out_ff <= stage_ff[LATENCY-1]; // RULE5 RULE6 RULE7 RULE10
				if (fill_ff == LATENCY[2:0])
					sample_valid_ff <= 1'b1; // RULE12
				else
					fill_ff <= fill_ff + 3'h1; // RULE12
			end
		end
	end

	assign sample_out          = sample_out_ff;
	assign sample_oe           = sample_oe_ff;
	assign sample_valid        = sample_valid_ff;
	assign internal_ref_active = int_ref_ff;

	// The stream cannot stall; a full FIFO drops and counts the word
	assign fifo_in_valid = ctrl_ff[`CTRL_CAPTURE_BIT] & sample_valid_ff;

	sample_fifo
	#(
		.WIDTH (SW),
		.DEPTH (DEPTH),
		.AW    (2)
	)
	u_fifo
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_data   (sample_out_ff),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.level     (fifo_level)
	);

	assign do_write   = aw_held_ff & w_held_ff & ~bvalid_ff;
	assign ar_take    = s_axi_arvalid & arready_ff;
	assign ar_is_data = (s_axi_araddr[3:2] == `REG_DATA_OFS >> 2);
	assign fifo_pop   = ar_take & ar_is_data;

	// Write channel: address and data accepted in either order
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			aw_addr_ff <= 4'h0;
			w_data_ff  <= 32'h0000_0000;
			w_strb_ff  <= 4'h0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `RESP_OKAY;
			ctrl_ff    <= `CTRL_RESET_VAL;
		end
		else
		begin
			awready_ff <= s_axi_awvalid & ~awready_ff & ~aw_held_ff & ~bvalid_ff;
			wready_ff  <= s_axi_wvalid & ~wready_ff & ~w_held_ff & ~bvalid_ff;
			if (s_axi_awvalid && awready_ff)
			begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_ff)
			begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held_ff <= 1'b0;
				w_held_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= `RESP_OKAY;
				case (aw_addr_ff[3:2])
					`REG_CTRL_OFS >> 2:
					begin
						if (w_strb_ff[0])
							ctrl_ff <= w_data_ff[1:0];
					end
					`REG_STATUS_OFS >> 2,
					`REG_DATA_OFS >> 2,
					`REG_DROP_OFS >> 2:
					begin
						// Read-only; writes are ignored
					end
					default:
					begin
						bresp_ff <= `RESP_SLVERR;
					end
				endcase
			end
			else if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	// Drop counter saturates rather than wraps, so a stale count is visible
	always @(posedge aclk)
	begin
		if (!aresetn)
			drop_ff <= 16'h0000;
		else if (fifo_in_valid && !fifo_in_ready && drop_ff != 16'hffff)
			drop_ff <= drop_ff + 16'h0001;
	end

	always @*
	begin
		nxt_rdata = 32'h0000_0000;
		nxt_rresp = `RESP_OKAY;
		case (s_axi_araddr[3:2])
			`REG_CTRL_OFS >> 2:
				nxt_rdata[1:0] = ctrl_ff;
			`REG_STATUS_OFS >> 2:
			begin
				nxt_rdata[`STAT_PD_BIT]    = pd_s;
				nxt_rdata[`STAT_SPAN_BIT]  = span_s;
				nxt_rdata[`STAT_REF_BIT]   = ref_s;
				nxt_rdata[`STAT_OEN_BIT]   = oen_s;
				nxt_rdata[`STAT_VALID_BIT] = sample_valid_ff;
				nxt_rdata[`STAT_LEVEL_LSB+2:`STAT_LEVEL_LSB] = fifo_level;
				nxt_rdata[`STAT_FULL_BIT]  = ~fifo_in_ready;
			end
			`REG_DATA_OFS >> 2:
			begin
				nxt_rdata[`DATA_VALID_BIT] = fifo_out_valid;
				nxt_rdata[SW-1:0] = fifo_out_data;
				if (ctrl_ff[`CTRL_TWOS_BIT])
					nxt_rdata[`CODE_MID_BIT] = ~fifo_out_data[`CODE_MID_BIT]; // RULE10
				if (!fifo_out_valid)
					nxt_rdata[SW-1:0] = {SW{1'b0}};
			end
			`REG_DROP_OFS >> 2:
				nxt_rdata[15:0] = drop_ff;
			default:
				nxt_rresp = `RESP_SLVERR;
		endcase
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= `RESP_OKAY;
		end
		else
		begin
			arready_ff <= s_axi_arvalid & ~arready_ff & ~rvalid_ff;
			if (ar_take)
			begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= nxt_rdata;
				rresp_ff  <= nxt_rresp;
			end
			else if (rvalid_ff && s_axi_rready)
				rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
endmodule

/* hdl/sample_fifo.v */
`timescale 1ns/1ps
module sample_fifo
#(
	parameter WIDTH = 10,
	parameter DEPTH = 4,
	parameter AW    = 2
)
(
	input  wire             aclk,
	input  wire             aresetn,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [AW:0]      level
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_ff;
	reg [AW-1:0]    rd_ptr_ff;
	reg [AW:0]      count_ff;
	wire            push;
	wire            pop;

	assign in_ready  = (count_ff != DEPTH[AW:0]);
	assign out_valid = (count_ff != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr_ff];
	assign level     = count_ff;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge aclk)
	begin
		if (push)
			mem[wr_ptr_ff] <= in_data;
	end

	// Pointers wrap at DEPTH so non power-of-two depths stay legal
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
			if (push && !pop)
				count_ff <= count_ff + 1'b1;
			else if (pop && !push)
				count_ff <= count_ff - 1'b1;
		end
	end
endmodule

/* hdl/sample_port_defines.vh */
`ifndef SAMPLE_PORT_DEFINES_VH
`define SAMPLE_PORT_DEFINES_VH

`define SAMPLE_WIDTH        10
`define LEVEL_WIDTH         11
`define PIPE_LATENCY        5
`define FIFO_DEPTH          4

`define REG_CTRL_OFS        4'h0
`define REG_STATUS_OFS      4'h4
`define REG_DATA_OFS        4'h8
`define REG_DROP_OFS        4'hc

`define CTRL_CAPTURE_BIT    0
`define CTRL_TWOS_BIT       1
`define CTRL_RESET_VAL      2'h0

`define STAT_PD_BIT         0
`define STAT_SPAN_BIT       1
`define STAT_REF_BIT        2
`define STAT_OEN_BIT        3
`define STAT_VALID_BIT      4
`define STAT_LEVEL_LSB      8
`define STAT_FULL_BIT       12

`define DATA_VALID_BIT      31

`define SPAN_1V_OFFSET      11'h200
`define CODE_MAX            10'h3ff
`define CODE_MID_BIT        9

`define PIN_OEN_DEFAULT     1'b0
`define PIN_SPAN_DEFAULT    1'b1
`define PIN_REF_DEFAULT     1'b1
`define PIN_PD_DEFAULT      1'b0

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* verif/capture_model.sv */
`timescale 1ns/1ps
module capture_model
(
	input wire logic       aclk,
	input wire logic       power_down_request,
	input wire logic [9:0] sample_out,
	input wire logic [9:0] sample_oe,
	output logic     [9:0] cap_word,
	output logic           cap_ok
);
	logic [9:0] held = '0;
	logic [9:0] bus;
	int         words = 0;

	// No pull on the data lines: released bits flip so stale levels never pass
	assign bus = (sample_oe & sample_out) | (~sample_oe & ~held);
	always @(posedge aclk)
	begin
		held <= bus;
		cap_word <= bus;
		words <= (power_down_request || sample_oe != 10'h3ff) ? 0 : words + 1;
		cap_ok <= words >= 5;
	end
endmodule

/* verif/sample_port_properties.sv */
`timescale 1ns/1ps
module sample_port_properties
#(
	parameter SW      = 10,
	parameter LW      = 11,
	parameter LATENCY = 5
)
(
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic [LW-1:0] analog_level,
	input wire logic          output_enable_n,
	input wire logic          power_down_request,
	input wire logic          input_span_select,
	input wire logic          reference_source_select,
	input wire logic [SW-1:0] sample_out,
	input wire logic [SW-1:0] sample_oe,
	input wire logic          sample_valid,
	input wire logic          internal_ref_active,
	input wire logic [1:0]    s_axi_bresp,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic [31:0]   s_axi_rdata,
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Levels outside the 1V window clamp to the end codes
	function automatic logic [SW-1:0] code_1v(input logic [LW-1:0] lv);
		if (lv < 11'h200)
			return '0;
		if (lv > 11'h5ff)
			return '1;
		return lv[SW-1:0] - 10'h200;
	endfunction

	// Pins pass two synchroniser flops and an output flop, so three samples are needed before an effect
	property p_float;
		output_enable_n [*3] |=> sample_oe == '0;
	endproperty
	property p_drive;
		!output_enable_n [*3] |=> sample_oe == '1;
	endproperty
	property p_pd;
		power_down_request [*3] |=> sample_out == '0 && !sample_valid;
	endproperty
	property p_ref;
		!reference_source_select [*3] |=> internal_ref_active;
	endproperty
	property p_lat_2v;
		sample_valid && $past(aresetn, 8) && $past(aresetn, 7) && $past(input_span_select, 8)
			|-> sample_out == $past(analog_level[LW-1:1], LATENCY + 1);
	endproperty
	property p_lat_1v;
		sample_valid && $past(aresetn, 8) && $past(aresetn, 7) && !$past(input_span_select, 8)
			|-> sample_out == code_1v($past(analog_level, LATENCY + 1));
	endproperty
	property p_valid_rise;
		$rose(sample_valid) |-> !$past(power_down_request, 4) && !$past(power_down_request, 6);
	endproperty
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty

	a_float: assert property (p_float) else $error("bus driven while disabled");
	a_drive: assert property (p_drive) else $error("bus not driven");
	a_pd: assert property (p_pd) else $error("output alive in power-down");
	a_ref: assert property (p_ref) else $error("internal reference not used");
	a_lat_2v: assert property (p_lat_2v) else $error("2V word wrong or late");
	a_lat_1v: assert property (p_lat_1v) else $error("1V word wrong or late");
	a_valid_rise: assert property (p_valid_rise) else $error("valid too early");
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	a_rhold: assert property (p_rhold) else $error("read data dropped");

	c_valid: cover property ($rose(sample_valid));
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind pipelined_adc_sample_port sample_port_properties #(.SW(SW), .LW(LW), .LATENCY(LATENCY))
	i_props (.aclk, .aresetn, .analog_level, .output_enable_n, .power_down_request,
	.input_span_select, .reference_source_select, .sample_out, .sample_oe, .sample_valid,
	.internal_ref_active, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready);

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic        aclk, aresetn, output_enable_n, power_down_request;
	logic        input_span_select, reference_source_select, sample_valid;
	logic        internal_ref_active, cap_ok;
	logic [10:0] analog_level;
	logic [9:0]  sample_out, sample_oe, cap_word;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	int          fails = 0;
	int          checks_done = 0;
	int          cycles = 0;
	int          n;
	// Span, level, expected code
	logic [21:0] rows [9] = '{{1'b1, 11'h000, 10'h000}, {1'b1, 11'h7ff, 10'h3ff},
		{1'b1, 11'h401, 10'h200}, {1'b0, 11'h1ff, 10'h000}, {1'b0, 11'h200, 10'h000},
		{1'b0, 11'h355, 10'h155}, {1'b0, 11'h5ff, 10'h3ff}, {1'b0, 11'h600, 10'h3ff},
		{1'b1, 11'h355, 10'h1aa}};

	pipelined_adc_sample_port i_dut (.aclk, .aresetn, .analog_level, .output_enable_n,
		.power_down_request, .input_span_select, .reference_source_select, .sample_out,
		.sample_oe, .sample_valid, .internal_ref_active, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	capture_model i_cap (.aclk, .power_down_request, .sample_out, .sample_oe, .cap_word,
		.cap_ok);

	initial
	begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end

	task report_and_stop;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d, input bit late = 0);
		logic aw_ok, w_ok;
		@(posedge aclk);
		aw_ok = 0;
		w_ok = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= !late;
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			aw_ok = aw_ok | (s_axi_awvalid & s_axi_awready);
			w_ok = w_ok | (s_axi_wvalid & s_axi_wready);
			s_axi_awvalid <= !aw_ok;
			s_axi_wvalid <= !w_ok;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		if (late)
		begin
			// Response kept waiting a cycle so its holding is exercised
			s_axi_bready <= 1;
			@(posedge aclk);
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask

	task rdr(input logic [3:0] a, input bit late = 0);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= !late;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		if (late)
		begin
			s_axi_rready <= 1;
			@(posedge aclk);
		end
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask

	// Guards against a handshake that never completes
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			fails++;
			report_and_stop();
		end
	end

	initial
	begin
		{aresetn, analog_level, output_enable_n, power_down_request} = '0;
		{input_span_select, reference_source_select} = 2'h3;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		repeat (16) @(posedge aclk);
		chk("oe_in_reset", 0, sample_oe);
		aresetn <= 1;
		foreach (rows[i])
		begin
			@(posedge aclk);
			{input_span_select, analog_level} <= rows[i][21:10];
			repeat (12) @(posedge aclk);
			chk("sample_out", rows[i][9:0], sample_out);
			chk("cap_word", rows[i][9:0], cap_word);
		end
		chk("cap_ok", 1, cap_ok);
		output_enable_n <= 1;
		repeat (4) @(posedge aclk);
		chk("oe_off", 0, sample_oe);
		output_enable_n <= 0;
		repeat (4) @(posedge aclk);
		chk("oe_on", 10'h3ff, sample_oe);
		power_down_request <= 1;
		repeat (4) @(posedge aclk);
		chk("pd_word", 0, {sample_valid, sample_out});
		power_down_request <= 0;
		for (n = 0; n < 20 && !sample_valid; n++)
			@(posedge aclk);
		chk("valid_delay", 1, n >= 8 && n <= 11);
		reference_source_select <= 0;
		repeat (4) @(posedge aclk);
		chk("int_ref", 1, internal_ref_active);
		rdr(4'h4);
		chk("status_ref", 0, rd[2]);
		reference_source_select <= 1;
		repeat (4) @(posedge aclk);
		chk("ext_ref", 0, internal_ref_active);
		rdr(4'h0);
		chk("ctrl_reset", 0, rd);
		wr(4'h0, 32'h1);
		repeat (12) @(posedge aclk);
		wr(4'h0, 32'h0);
		rdr(4'h4);
		chk("fifo_full", 5'h14, rd[12:8]);
		rdr(4'h8, 1);
		chk("data_sob", 32'h800001aa, rd);
		wr(4'h0, 32'h2);
		repeat (3)
		begin
			rdr(4'h8);
			chk("data_twos", 32'h800003aa, rd);
		end
		rdr(4'h8);
		chk("data_empty", 0, rd);
		rdr(4'hc);
		chk("drops", 1, rd != 0);
		chk("rresp", 0, rsp);
		wr(4'h4, 32'hffff, 1);
		chk("ro_resp", 0, rsp);
		rdr(4'h0);
		chk("ctrl", 2, rd);
		// Low byte strobe off: control must keep its value
		s_axi_wstrb <= 4'he;
		wr(4'h0, 32'h1);
		s_axi_wstrb <= 4'hf;
		rdr(4'h0);
		chk("ctrl_strb", 2, rd);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		chk("mid_reset", 0, {sample_valid, internal_ref_active, sample_oe, sample_out});
		aresetn <= 1;
		rdr(4'h0);
		chk("ctrl_after_reset", 0, rd);
		report_and_stop();
	end
endmodule
